// >>> hw/eii_pkg.sv
// Purpose: constants for the external interrupt input stage
// Assumes: 32-bit AXI4-Lite register port, 40 MHz aclk
// Notes: register offsets are byte addresses
//
// Notes on behaviour
// - nmi synchronized, then rising edge latched
// - nmi taken only at instruction boundary
// - unmasked request steers to its vector
// - each input synchronized, edge or level
// - software selects active polarity per input
// - same input ignored until acknowledged
// - nmi highest priority, never masked
// - nmi has no in-service bit; preempts
// - any accepted interrupt clears global enable
package eii_pkg;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00; // bit0 global enable
  localparam logic [7:0] ADDR_MASK = 8'h04; // 1 = masked
  localparam logic [7:0] ADDR_MODE = 8'h08; // 1 = level, 0 = edge
  localparam logic [7:0] ADDR_POL = 8'h0C; // 1 = active low
  localparam logic [7:0] ADDR_PEND = 8'h10; // ro pending requests
  localparam logic [7:0] ADDR_STAT = 8'h14; // ro sticky events
  localparam logic [7:0] ADDR_CLR = 8'h18; // wo status clear
  localparam logic [7:0] ADDR_IEN = 8'h1C; // status interrupt enable
  localparam logic [7:0] ADDR_ACK = 8'h20; // wo acknowledge
  localparam logic [7:0] ADDR_RAW = 8'h24; // ro synchronized pins
  localparam logic [7:0] ADDR_INSVC = 8'h28; // ro in-service

  // -----------------------------------------------------------------
  // fields and reset values
  // -----------------------------------------------------------------
  localparam int NUM_INT = 9;
  localparam int STAT_W = 11; // 8:0 requests, 9 nmi, 10 accept
  localparam int STAT_NMI = 9;
  localparam int STAT_TAKE = 10;
  localparam int CTRL_GIE = 0;
  localparam logic [8:0] RST_MASK = 9'h1FF;
  localparam logic [8:0] RST_MODE = 9'h000;
  localparam logic [8:0] RST_POL = 9'h000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : eii_pkg

// >>> hw/eii_sync.sv
// Purpose: two-flop synchronizer for asynchronous pins
// Assumes: one clock, synchronous active-low reset
// Notes: first stage feeds only the second stage
module eii_sync #(
  parameter int WIDTH = 10
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  // two stages, frozen while clk_en low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule : eii_sync

// >>> hw/eii_top.sv
// Purpose: nmi and nine maskable external interrupt inputs
// Assumes: core gives boundary strobe and acknowledges
// Notes: among maskable inputs lowest index wins
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
module eii_top (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // external request pins
  input wire logic nmi_request_in,
  input wire logic [5:0] maskable_request_in_low,
  input wire logic maskable_request_in_six,
  input wire logic maskable_request_in_seven,
  input wire logic maskable_request_in_eight,
  // core side
  input wire logic instr_boundary,
  input wire logic [8:0] core_ack,
  output logic take_nmi_ff,
  output logic take_int_ff,
  output logic [3:0] take_vec_ff,
  output logic gie_ff,
  output logic irq_ff,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int N = eii_pkg::NUM_INT;

  logic [N:0] pin_sync;
  logic [N-1:0] mask_ff, mode_ff, pol_ff, pend_ff, insvc_ff, act_d_ff;
  logic [N-1:0] act, setreq, ack_all, sw_ack, cand;
  logic [eii_pkg::STAT_W-1:0] stat_ff, ien_ff, stat_clr, stat_ev;
  logic nmi_d_ff, nmi_pend_ff, nmi_rise;
  logic [3:0] pick;
  logic pick_ok, take_nmi, take_int;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_ok, w_ok, wr_fire, wr_hit;

  // -----------------------------------------------------------------
  // pin synchronization
  // -----------------------------------------------------------------
  // all pins cross here before any other logic
  eii_sync #(.WIDTH(N + 1)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .async_in({nmi_request_in, maskable_request_in_eight, maskable_request_in_seven,
               maskable_request_in_six, maskable_request_in_low}),
    .sync_out(pin_sync)
  );

  // -----------------------------------------------------------------
  // nmi path
  // -----------------------------------------------------------------
  assign nmi_rise = pin_sync[N] & ~nmi_d_ff;

  // rising edge latch; a new edge may re-arm during a handler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_d_ff <= 1'b0;
      nmi_pend_ff <= 1'b0;
    end else if (clk_en) begin
      nmi_d_ff <= pin_sync[N];
      nmi_pend_ff <= nmi_rise | (nmi_pend_ff & ~take_nmi);
    end
  end

  // -----------------------------------------------------------------
  // maskable request latches
  // -----------------------------------------------------------------
  assign ack_all = core_ack | sw_ack;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_req
      // polarity flip then edge or level detect
      assign act[gi] = pin_sync[gi] ^ pol_ff[gi];
      assign setreq[gi] = ~pend_ff[gi] & (mode_ff[gi] ? act[gi] : act[gi] & ~act_d_ff[gi]);

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          act_d_ff[gi] <= 1'b0;
          pend_ff[gi] <= 1'b0;
          insvc_ff[gi] <= 1'b0;
        end else if (clk_en) begin
          act_d_ff[gi] <= act[gi];
          pend_ff[gi] <= setreq[gi] | (pend_ff[gi] & ~ack_all[gi]);
          insvc_ff[gi] <= (take_int && pick == 4'(gi)) | (insvc_ff[gi] & ~ack_all[gi]);
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // acceptance at instruction boundary
  // -----------------------------------------------------------------
  assign cand = pend_ff & ~insvc_ff & ~mask_ff;

  // lowest pending unmasked input that is not in service
  always_comb begin
    pick = 4'h0;
    pick_ok = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (cand[i]) begin
        pick = 4'(i);
        pick_ok = 1'b1;
      end
    end
  end

  assign take_nmi = instr_boundary & nmi_pend_ff;
  assign take_int = instr_boundary & ~nmi_pend_ff & gie_ff & pick_ok;

  // acceptance strobes and vector to the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      take_nmi_ff <= 1'b0;
      take_int_ff <= 1'b0;
      take_vec_ff <= 4'h0;
    end else if (clk_en) begin
      take_nmi_ff <= take_nmi;
      take_int_ff <= take_int;
      if (take_int) begin
        take_vec_ff <= pick;
      end
    end
  end

  // global enable: software sets, any acceptance clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gie_ff <= 1'b0;
    end else if (clk_en) begin
      if (take_nmi || take_int) begin
        gie_ff <= 1'b0;
      end else if (wr_hit && awaddr_ff == eii_pkg::ADDR_CTRL && wstrb_ff[0]) begin
        gie_ff <= wdata_ff[eii_pkg::CTRL_GIE];
      end
    end
  end

  // -----------------------------------------------------------------
  // status and interrupt line
  // -----------------------------------------------------------------
  assign stat_ev = {take_nmi | take_int, nmi_rise, setreq};
  assign stat_clr = (wr_hit && awaddr_ff == eii_pkg::ADDR_CLR) ? wdata_ff[eii_pkg::STAT_W-1:0] : '0;
  assign sw_ack = (wr_hit && awaddr_ff == eii_pkg::ADDR_ACK) ? wdata_ff[N-1:0] : '0;

  // sticky bits, a new event wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_ff <= '0;
      irq_ff <= 1'b0;
    end else if (clk_en) begin
      stat_ff <= stat_ev | (stat_ff & ~stat_clr);
      irq_ff <= |(stat_ff & ien_ff);
    end
  end

  // -----------------------------------------------------------------
  // axi4-lite write side
  // -----------------------------------------------------------------
  assign aw_ok = s_axi_awvalid & s_axi_awready;
  assign w_ok = s_axi_wvalid & s_axi_wready;
  assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_hit = clk_en & wr_fire;

  // take address and data in either order, answer once both held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= eii_pkg::RESP_OKAY;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (clk_en) begin
      if (aw_ok) begin
        awaddr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_ok) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        case (awaddr_ff)
          eii_pkg::ADDR_CTRL, eii_pkg::ADDR_MASK, eii_pkg::ADDR_MODE, eii_pkg::ADDR_POL,
          eii_pkg::ADDR_CLR, eii_pkg::ADDR_IEN, eii_pkg::ADDR_ACK: s_axi_bresp <= eii_pkg::RESP_OKAY;
          default: s_axi_bresp <= eii_pkg::RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // control registers, low two byte lanes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_ff <= eii_pkg::RST_MASK;
      mode_ff <= eii_pkg::RST_MODE;
      pol_ff <= eii_pkg::RST_POL;
      ien_ff <= '0;
    end else if (wr_hit && wstrb_ff[1:0] == 2'b11) begin
      case (awaddr_ff)
        eii_pkg::ADDR_MASK: mask_ff <= wdata_ff[N-1:0];
        eii_pkg::ADDR_MODE: mode_ff <= wdata_ff[N-1:0];
        eii_pkg::ADDR_POL: pol_ff <= wdata_ff[N-1:0];
        eii_pkg::ADDR_IEN: ien_ff <= wdata_ff[eii_pkg::STAT_W-1:0];
        default: ;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // axi4-lite read side
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= eii_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= eii_pkg::RESP_OKAY;
        case (s_axi_araddr)
          eii_pkg::ADDR_CTRL: s_axi_rdata <= {31'h0, gie_ff};
          eii_pkg::ADDR_MASK: s_axi_rdata <= {23'h0, mask_ff};
          eii_pkg::ADDR_MODE: s_axi_rdata <= {23'h0, mode_ff};
          eii_pkg::ADDR_POL: s_axi_rdata <= {23'h0, pol_ff};
          eii_pkg::ADDR_PEND: s_axi_rdata <= {22'h0, nmi_pend_ff, pend_ff};
          eii_pkg::ADDR_STAT: s_axi_rdata <= {21'h0, stat_ff};
          eii_pkg::ADDR_IEN: s_axi_rdata <= {21'h0, ien_ff};
          eii_pkg::ADDR_RAW: s_axi_rdata <= {22'h0, pin_sync};
          eii_pkg::ADDR_INSVC: s_axi_rdata <= {23'h0, insvc_ff};
          eii_pkg::ADDR_CLR, eii_pkg::ADDR_ACK: s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= eii_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : eii_top

// >>> testbench/eii_src.sv
// Purpose: board-level request sources
// Assumes: push-pull pins, idle low
// Notes: hold time given per call
module eii_src (
  // clock
  input wire logic aclk,
  // request pins
  output logic nmi_request_in,
  output logic [5:0] maskable_request_in_low,
  output logic maskable_request_in_six,
  output logic maskable_request_in_seven,
  output logic maskable_request_in_eight
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] pin_ff = 10'h000;
  // bit 9 nmi, bits 8:0 maskable
  assign {nmi_request_in, maskable_request_in_eight, maskable_request_in_seven, maskable_request_in_six,
    maskable_request_in_low} = pin_ff;
  // set one pin, hold it for the asked cycles
  task automatic drive(input int idx, input logic lvl, input int hold);
    @(posedge aclk);
    pin_ff[idx] <= lvl;
    repeat (hold) @(posedge aclk);
  endtask : drive
endmodule : eii_src

// >>> testbench/eii_top_chk.sv
// Purpose: port checks for the interrupt input stage
// Assumes: clk_en high while checked
// Notes: bound to eii_top below
module eii_top_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // core side
  input wire logic instr_boundary,
  input wire logic take_nmi_ff,
  input wire logic take_int_ff,
  input wire logic [3:0] take_vec_ff,
  input wire logic gie_ff,
  // read channel
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // acceptance only after a boundary cycle
  property p_int_bnd; take_int_ff |-> $past(instr_boundary); endproperty
  a_int_bnd: assert property (p_int_bnd) else $error("int taken off boundary");
  property p_nmi_bnd; take_nmi_ff |-> $past(instr_boundary); endproperty
  a_nmi_bnd: assert property (p_nmi_bnd) else $error("nmi taken off boundary");
  // any acceptance drops global enable
  property p_int_gie; take_int_ff |-> !gie_ff; endproperty
  a_int_gie: assert property (p_int_gie) else $error("gie kept on int");
  property p_nmi_gie; take_nmi_ff |-> !gie_ff; endproperty
  a_nmi_gie: assert property (p_nmi_gie) else $error("gie kept on nmi");
  // maskable needs enable, loses to nmi
  property p_int_en; take_int_ff |-> $past(gie_ff); endproperty
  a_int_en: assert property (p_int_en) else $error("int taken while disabled");
  property p_nmi_wins; take_int_ff |-> !take_nmi_ff; endproperty
  a_nmi_wins: assert property (p_nmi_wins) else $error("int beside nmi");
  // one-cycle pulse, legal index
  property p_int_pulse; take_int_ff |=> !take_int_ff; endproperty
  a_int_pulse: assert property (p_int_pulse) else $error("int pulse too long");
  property p_vec; take_int_ff |-> take_vec_ff < 4'h9; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_nmi_pulse; take_nmi_ff |=> !take_nmi_ff; endproperty
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi pulse too long");
  property p_rd_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rd_once: assert property (p_rd_once) else $error("read answered twice");
endmodule : eii_top_chk

bind eii_top eii_top_chk u_chk (.aclk, .aresetn, .instr_boundary, .take_nmi_ff, .take_int_ff,
  .take_vec_ff, .gie_ff, .s_axi_rvalid, .s_axi_rready);

// >>> testbench/tb_top.sv
// Purpose: self-checking bench for the interrupt input stage
// Assumes: wstrb held on, clk_en held on except while t_level freezes it
// Notes: registers reached over axi4-lite
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1, instr_boundary = 1'h0;
  logic [8:0] core_ack = 9'h000;
  wire logic nmi_request_in, maskable_request_in_six, maskable_request_in_seven, maskable_request_in_eight;
  wire logic [5:0] maskable_request_in_low;
  logic take_nmi_ff, take_int_ff, gie_ff, irq_ff;
  logic [3:0] take_vec_ff;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
  int miscompares = 0;
  int check_count = 0;
  eii_top uut (.aclk, .aresetn, .clk_en, .nmi_request_in, .maskable_request_in_low, .maskable_request_in_six,
    .maskable_request_in_seven, .maskable_request_in_eight, .instr_boundary, .core_ack, .take_nmi_ff,
    .take_int_ff, .take_vec_ff, .gie_ff, .irq_ff, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  eii_src src (.aclk, .nmi_request_in, .maskable_request_in_low, .maskable_request_in_six,
    .maskable_request_in_seven, .maskable_request_in_eight);
  // clock
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  task automatic wrap_up;
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // axi write, channels released as taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    bs = s_axi_bresp;
    s_axi_bready <= 1'h0;
    // one idle edge before the next request
    @(posedge aclk);
  endtask : wr
  // axi read into rv and rs
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    // one idle edge before the next request
    @(posedge aclk);
  endtask : rd
  // wait for a take pulse
  task automatic wt(ref logic s);
    int n = 0;
    while (s !== 1'h1 && n < 30) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(s), 32'h0000_0001);
  endtask : wt
  task automatic t_reset;
    rd(eii_pkg::ADDR_MASK);
    chk(rv, 32'(eii_pkg::RST_MASK));
    rd(eii_pkg::ADDR_MODE);
    chk(rv, 32'(eii_pkg::RST_MODE));
    rd(8'h3C);
    chk(32'(rs), 32'(eii_pkg::RESP_SLVERR));
    wr(eii_pkg::ADDR_PEND, 32'h0000_0001);
    chk(32'(bs), 32'(eii_pkg::RESP_SLVERR));
  endtask : t_reset
  task automatic t_edge;
    wr(eii_pkg::ADDR_MASK, 32'h0000_01FB);
    chk(32'(bs), 32'(eii_pkg::RESP_OKAY));
    wr(eii_pkg::ADDR_CTRL, 32'h0000_0001);
    src.drive(2, 1'h1, 6);
    src.drive(2, 1'h0, 6);
    src.drive(2, 1'h1, 6);
    rd(eii_pkg::ADDR_PEND);
    chk(rv, 32'h0000_0004);
    instr_boundary <= 1'h1;
    wt(take_int_ff);
    chk(32'(take_vec_ff), 32'h0000_0002);
    chk(32'(gie_ff), 32'h0000_0000);
    instr_boundary <= 1'h0;
    core_ack <= 9'h004;
    @(posedge aclk);
    core_ack <= 9'h000;
    src.drive(2, 1'h0, 6);
    rd(eii_pkg::ADDR_PEND);
    chk(rv, 32'h0000_0000);
  endtask : t_edge
  task automatic t_nmi;
    wr(eii_pkg::ADDR_MASK, 32'h0000_01FF);
    wr(eii_pkg::ADDR_CTRL, 32'h0000_0001);
    instr_boundary <= 1'h1;
    src.drive(9, 1'h1, 2);
    wt(take_nmi_ff);
    chk(32'(gie_ff), 32'h0000_0000);
    src.drive(9, 1'h0, 2);
    src.drive(9, 1'h1, 2);
    wt(take_nmi_ff);
    instr_boundary <= 1'h0;
    src.drive(9, 1'h0, 2);
  endtask : t_nmi
  task automatic t_irq;
    chk(32'(irq_ff), 32'h0000_0000);
    wr(eii_pkg::ADDR_IEN, 32'h0000_0200);
    repeat (3) @(posedge aclk);
    chk(32'(irq_ff), 32'h0000_0001);
    wr(eii_pkg::ADDR_CLR, 32'h0000_0200);
    repeat (3) @(posedge aclk);
    chk(32'(irq_ff), 32'h0000_0000);
  endtask : t_irq
  task automatic t_level;
    wr(eii_pkg::ADDR_MODE, 32'h0000_0080);
    wr(eii_pkg::ADDR_POL, 32'h0000_0080);
    repeat (4) @(posedge aclk);
    rd(eii_pkg::ADDR_PEND);
    chk(rv, 32'h0000_0080);
    src.drive(7, 1'h1, 6);
    wr(eii_pkg::ADDR_ACK, 32'h0000_0080);
    rd(eii_pkg::ADDR_PEND);
    chk(rv, 32'h0000_0000);
    // pin moves while frozen: synchronizer must still show the old level
    clk_en <= 1'h0;
    src.drive(7, 1'h0, 6);
    clk_en <= 1'h1;
    rd(eii_pkg::ADDR_RAW);
    chk(rv, 32'h0000_0080);
    rd(eii_pkg::ADDR_PEND);
    chk(rv, 32'h0000_0080);
  endtask : t_level
  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_edge();
    t_nmi();
    t_irq();
    t_level();
    wrap_up();
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge aclk);
    miscompares++;
    wrap_up();
  end
endmodule : tb_top
